/* adc_result_format_pkg.sv */
`default_nettype none
package adc_result_format_pkg;
    // register indices on the byte-wide register port
    localparam logic [2:0] ADDR_RESULT_LOW  = 3'h0;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
    localparam logic [2:0] ADDR_MUX_CONFIG  = 3'h2;
    localparam logic [2:0] ADDR_CONTROL_B   = 3'h3;
    localparam logic [2:0] ADDR_STATUS      = 3'h4;
    // field positions
    localparam int BIPOLAR_SELECT_BIT = 7;
    localparam int DONE_FLAG_BIT      = 4;
    localparam int DIFF_SELECT_BIT    = 4;
    localparam int GAIN_SELECT_BIT    = 0;
    // reset values
    localparam logic [7:0] MUX_CONFIG_RESET = 8'h00;
    localparam logic       BIPOLAR_RESET    = 1'b0;
    // code limits
    localparam logic [9:0]        CODE_ZERO   = 10'h000;
    localparam logic [9:0]        CODE_MAX    = 10'h3FF;
    localparam logic signed [17:0] UNI_MAX    = 18'sh0_03FF;
    localparam logic signed [17:0] BIP_MAX    = 18'sh0_01FF;
    localparam logic signed [17:0] BIP_MIN    = -18'sh0_0200;
    localparam logic [9:0]        BIP_MIN_CODE = 10'h200;
    localparam logic [9:0]        BIP_MAX_CODE = 10'h1FF;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef struct packed {
        logic              valid;
        logic signed [11:0] value;
    } sample_type;

    typedef struct packed {
        logic [9:0] result;
        logic [7:0] mux_config;
        logic       bipolar;
        logic       done;
        logic [7:0] rdata;
    } state_type;
endpackage
`default_nettype wire

/* adc_result_format.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - after a finished conversion the result is readable in low/high bytes
// - result registers and the done flag are updated in the same cycle
// - single-ended result is unsigned 0x000 (ground) to 0x3FF
// - pairs run unipolar unless bipolar select is set, as after reset
// - unipolar differential is unsigned full range; negative clamps to zero
// - writing one to bipolar select in control b enables signed differences
// - bipolar result is two's complement at half scale, 0x200 to 0x1FF
// - in bipolar mode bit 9 carries the sign, one means negative
// - differential pairs get gain 8 or 20 picked by the input select field
module adc_result_format
    import adc_result_format_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire bus_req_type bus_req,
    input  wire sample_type  sample,
    output logic [7:0]       rdata,
    output logic             conversion_done_flag,
    output logic [4:0]       input_select_field,
    output logic [1:0]       reference_select
);
    state_type          state_reg;
    state_type          state_next;
    logic               differential;
    logic               gain_20;
    logic signed [17:0] sample_ext;
    logic signed [17:0] gained;
    logic signed [17:0] halved;
    logic [9:0]         formatted;

    always_comb begin
        differential = state_reg.mux_config[DIFF_SELECT_BIT];
        gain_20      = state_reg.mux_config[GAIN_SELECT_BIT];
        sample_ext   = {{6{sample.value[11]}}, sample.value};
        if (differential) begin
            if (gain_20) begin
                gained = (sample_ext <<< 4) + (sample_ext <<< 2);
            end else begin
                gained = sample_ext <<< 3;
            end
        end else begin
            gained = sample_ext;
        end
        halved = gained >>> 1;
        if (differential && state_reg.bipolar) begin
            if (halved > BIP_MAX) begin
                formatted = BIP_MAX_CODE;
            end else if (halved < BIP_MIN) begin
                formatted = BIP_MIN_CODE;
            end else begin
                formatted = halved[9:0];
            end
        end else begin
            if (gained < 18'sh0_0000) begin
                formatted = CODE_ZERO;
            end else if (gained > UNI_MAX) begin
                formatted = CODE_MAX;
            end else begin
                formatted = gained[9:0];
            end
        end
    end

    always_comb begin
        state_next       = state_reg;
        state_next.rdata = 8'h00;
        if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_MUX_CONFIG: begin
                    state_next.mux_config = bus_req.wdata;
                end
                ADDR_CONTROL_B: begin
                    state_next.bipolar =
                        bus_req.wdata[BIPOLAR_SELECT_BIT];
                end
                ADDR_STATUS: begin
                    if (bus_req.wdata[DONE_FLAG_BIT]) begin
                        state_next.done = 1'b0;
                    end
                end
                default: begin
                    state_next.done = state_reg.done;
                end
            endcase
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_RESULT_LOW: begin
                    state_next.rdata = state_reg.result[7:0];
                end
                ADDR_RESULT_HIGH: begin
                    state_next.rdata = {6'h00, state_reg.result[9:8]};
                end
                ADDR_MUX_CONFIG: begin
                    state_next.rdata = state_reg.mux_config;
                end
                ADDR_CONTROL_B: begin
                    state_next.rdata = {state_reg.bipolar, 7'h00};
                end
                ADDR_STATUS: begin
                    state_next.rdata = {3'h0, state_reg.done, 4'h0};
                end
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end
        // set wins over a clear in the same cycle
        if (sample.valid) begin
            state_next.result = formatted;
            state_next.done   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg.result     <= CODE_ZERO;
            state_reg.mux_config <= MUX_CONFIG_RESET;
            state_reg.bipolar    <= BIPOLAR_RESET;
            state_reg.done       <= 1'b0;
            state_reg.rdata      <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        rdata                = state_reg.rdata;
        conversion_done_flag = state_reg.done;
        input_select_field   = state_reg.mux_config[4:0];
        reference_select     = state_reg.mux_config[7:6];
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_done_with_result;
        sample.valid |=> state_reg.done && state_reg.result == $past(formatted);
    endproperty
    a_done_with_result: assert property (p_done_with_result)
        else $error("result and done flag not updated together");

    property p_low_byte;
        bus_req.rd && bus_req.addr == ADDR_RESULT_LOW && !sample.valid
            |=> rdata == state_reg.result[7:0];
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low byte read mismatch");

    property p_high_byte;
        bus_req.rd && bus_req.addr == ADDR_RESULT_HIGH && !sample.valid
            |=> rdata == {6'h00, state_reg.result[9:8]};
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("high byte read mismatch");

    property p_single_saturate;
        sample.valid && !differential && sample.value > 12'sd1023
            |=> state_reg.result == CODE_MAX;
    endproperty
    a_single_saturate: assert property (p_single_saturate)
        else $error("single-ended code not saturated to full scale");

    property p_unipolar_clamp;
        sample.valid && differential && !state_reg.bipolar
            && sample.value < 12'sd0 |=> state_reg.result == CODE_ZERO;
    endproperty
    a_unipolar_clamp: assert property (p_unipolar_clamp)
        else $error("negative unipolar difference not clamped to zero");

    property p_gain_20;
        sample.valid && differential && gain_20 && !state_reg.bipolar
            && sample.value == 12'sd1 |=> state_reg.result == 10'h014;
    endproperty
    a_gain_20: assert property (p_gain_20)
        else $error("gain of twenty not applied");

    property p_bipolar_sign;
        sample.valid && differential && state_reg.bipolar
            && sample.value < 12'sd0 |=> state_reg.result[9];
    endproperty
    a_bipolar_sign: assert property (p_bipolar_sign)
        else $error("bipolar negative result lacks sign bit");

    property p_bipolar_floor;
        sample.valid && differential && state_reg.bipolar
            && sample.value == -12'sd2048 |=> state_reg.result == BIP_MIN_CODE;
    endproperty
    a_bipolar_floor: assert property (p_bipolar_floor)
        else $error("bipolar code not saturated at most negative");

    property p_bipolar_write;
        bus_req.wr && bus_req.addr == ADDR_CONTROL_B
            |=> state_reg.bipolar == $past(bus_req.wdata[BIPOLAR_SELECT_BIT]);
    endproperty
    a_bipolar_write: assert property (p_bipolar_write)
        else $error("bipolar select write not taken");

    property p_reset_unipolar;
        @(posedge clk) disable iff (1'b0)
            sys_rst |=> !state_reg.bipolar;
    endproperty
    a_reset_unipolar: assert property (p_reset_unipolar)
        else $error("bipolar select not cleared by reset");

    property p_single_zero;
        sample.valid && !differential && sample.value < 12'sh000
            |=> state_reg.result == CODE_ZERO;
    endproperty
    a_single_zero: assert property (p_single_zero)
        else $error("negative single-ended input not floored at zero");

    property p_unipolar_saturate;
        sample.valid && differential && !state_reg.bipolar
            && sample.value == 12'sh7FF |=> state_reg.result == CODE_MAX;
    endproperty
    a_unipolar_saturate: assert property (p_unipolar_saturate)
        else $error("unipolar code not saturated at full scale");

    property p_gain_8;
        sample.valid && differential && !gain_20 && !state_reg.bipolar
            && sample.value == 12'sh001 |=> state_reg.result == 10'h008;
    endproperty
    a_gain_8: assert property (p_gain_8)
        else $error("gain of eight not applied");

    property p_bipolar_ceiling;
        sample.valid && differential && state_reg.bipolar
            && sample.value == 12'sh7FF |=> state_reg.result == BIP_MAX_CODE;
    endproperty
    a_bipolar_ceiling: assert property (p_bipolar_ceiling)
        else $error("bipolar code not saturated at most positive");

    property p_bipolar_positive;
        sample.valid && differential && state_reg.bipolar
            && sample.value > 12'sh000 |=> !state_reg.result[9];
    endproperty
    a_bipolar_positive: assert property (p_bipolar_positive)
        else $error("bipolar positive result carries sign bit");

    property p_result_hold;
        !sample.valid |=> $stable(state_reg.result);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed without a finished conversion");

    property p_done_hold;
        !sample.valid && !(bus_req.wr && bus_req.addr == ADDR_STATUS
            && bus_req.wdata[DONE_FLAG_BIT]) |=> $stable(state_reg.done);
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done flag changed without set or clear");

    property p_done_clear;
        !sample.valid && bus_req.wr && bus_req.addr == ADDR_STATUS
            && bus_req.wdata[DONE_FLAG_BIT] |=> !state_reg.done;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done flag not cleared by status write");

    property p_mux_write;
        bus_req.wr && bus_req.addr == ADDR_MUX_CONFIG
            |=> state_reg.mux_config == $past(bus_req.wdata);
    endproperty
    a_mux_write: assert property (p_mux_write)
        else $error("input select configuration write not taken");

    property p_status_read;
        bus_req.rd && !bus_req.wr && bus_req.addr == ADDR_STATUS
            && !sample.valid |=> rdata == {3'h0, state_reg.done, 4'h0};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("done flag read mismatch");

    property p_control_read;
        bus_req.rd && !bus_req.wr && bus_req.addr == ADDR_CONTROL_B
            |=> rdata == {state_reg.bipolar, 7'h00};
    endproperty
    a_control_read: assert property (p_control_read)
        else $error("bipolar select read mismatch");

    property p_rdata_idle;
        !bus_req.rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle outside a read");

    property p_unmapped_read;
        bus_req.rd && bus_req.addr > ADDR_STATUS |=> rdata == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped index read not zero");

    c_bipolar_negative: cover property (sample.valid && differential
        && state_reg.bipolar && sample.value < 12'sd0);
    c_clear_and_set: cover property (sample.valid && bus_req.wr
        && bus_req.addr == ADDR_STATUS && bus_req.wdata[DONE_FLAG_BIT]);
    c_done_then_read: cover property (sample.valid ##[1:2] bus_req.rd
        && bus_req.addr == ADDR_RESULT_LOW ##[1:2] bus_req.rd
        && bus_req.addr == ADDR_RESULT_HIGH);
    c_gain_20_bipolar: cover property (sample.valid && differential
        && gain_20 && state_reg.bipolar);
    c_unipolar_overflow: cover property (sample.valid && differential
        && !state_reg.bipolar && gained > UNI_MAX);
endmodule // adc_result_format
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import adc_result_format_pkg::*;
;
    logic               clk;
    logic               sys_rst;
    bus_req_type        bus_req;
    sample_type         sample;
    logic [7:0]         rdata;
    logic               conversion_done_flag;
    logic [4:0]         input_select_field;
    logic [1:0]         reference_select;
    int                 mismatches;
    int                 checks_done;
    logic [7:0]         rd_val;
    logic [9:0]         last_e;
    logic signed [11:0] corners [7] = '{-12'sd2048, -12'sd1, 12'sd0, 12'sd1,
                                        12'sd25, 12'sd1023, 12'sd2047};
    // single-ended code of the temperature sensor and the 1.1V reference
    localparam logic [4:0] SENSOR_SELECT = 5'h0A;
    localparam logic [1:0] SENSOR_REF    = 2'h1;

    adc_result_format i_adc_result_format (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .bus_req              (bus_req),
        .sample               (sample),
        .rdata                (rdata),
        .conversion_done_flag (conversion_done_flag),
        .input_select_field   (input_select_field),
        .reference_select     (reference_select)
    );

    function automatic logic [9:0] fmt(input logic [4:0] s, input logic b,
                                       input logic signed [11:0] v);
        int g;
        g = int'(v);
        if (s[4]) g = g * (s[0] ? 20 : 8);
        if (s[4] && b) begin
            g = g >>> 1;
            g = (g > 511) ? 511 : ((g < -512) ? -512 : g);
        end else g = (g > 1023) ? 1023 : ((g < 0) ? 0 : g);
        return g[9:0];
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [9:0] seen,
                       input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic convert(input logic [4:0] s, input logic b,
                           input logic signed [11:0] v, input logic wb);
        logic [1:0] r;
        r = 2'($urandom);
        last_e = fmt(s, b, v);
        bus_wr(ADDR_MUX_CONFIG, {r, 1'b0, s});
        if (wb) bus_wr(ADDR_CONTROL_B, {b, 7'h00});
        chk("input_select", 10'(input_select_field), 10'(s));
        chk("reference", 10'(reference_select), 10'(r));
        @(posedge clk);
        sample <= '{valid: 1'b1, value: v};
        @(posedge clk);
        sample.valid <= 1'b0;
        #1 chk("done_flag", 10'(conversion_done_flag), 10'h001);
        bus_rd(ADDR_RESULT_LOW, rd_val);
        chk("result_low", 10'(rd_val), 10'(last_e[7:0]));
        bus_rd(ADDR_RESULT_HIGH, rd_val);
        chk("result_high", 10'(rd_val), 10'(last_e[9:8]));
        bus_wr(ADDR_STATUS, 8'h10);
        chk("done_clear", 10'(conversion_done_flag), 10'h000);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("MISMATCH watchdog expected end seen hang");
        stop_test();
    end

    initial begin
        sys_rst = 1'b1;
        bus_req = '0;
        sample = '0;
        mismatches = 0;
        checks_done = 0;
        void'($urandom(32'h0000_0169));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk("reset_flag", 10'(conversion_done_flag), 10'h000);
        for (int a = 0; a < 8; a++) begin
            bus_rd(3'(a), rd_val);
            chk("reset_read", 10'(rd_val), 10'h000);
        end
        @(posedge clk);
        #1 chk("rdata_idle", 10'(rdata), 10'h000);
        $display("test reset done");
        convert(5'h10, 1'b0, -12'sd3, 1'b0);
        convert(5'h11, 1'b0, 12'sd60, 1'b0);
        convert(5'h13, 1'b0, 12'sd1, 1'b0);
        $display("test unipolar default done");
        foreach (corners[i]) begin
            convert({1'b0, 4'($urandom)}, 1'b1, corners[i], 1'b1);
            convert(5'h10, 1'b1, corners[i], 1'b1);
            convert(5'h1B, 1'b1, corners[i], 1'b1);
            convert(5'h16, 1'b0, corners[i], 1'b1);
        end
        $display("test corners done");
        bus_wr(ADDR_RESULT_LOW, 8'hAA);
        bus_wr(3'h5, 8'hFF);
        bus_rd(ADDR_RESULT_LOW, rd_val);
        chk("result_ro", 10'(rd_val), 10'(last_e[7:0]));
        $display("test read only done");
        @(posedge clk);
        sample <= '{valid: 1'b1, value: 12'sd7};
        bus_req <= '{addr: ADDR_STATUS, wdata: 8'h10, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        sample.valid <= 1'b0;
        bus_req.wr <= 1'b0;
        #1 chk("set_wins", 10'(conversion_done_flag), 10'h001);
        $display("test set wins done");
        bus_wr(ADDR_CONTROL_B, 8'h80);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk("reset_again", 10'(conversion_done_flag), 10'h000);
        bus_rd(ADDR_CONTROL_B, rd_val);
        chk("reset_unipolar", 10'(rd_val), 10'h000);
        $display("test mid-run reset done");
        bus_wr(ADDR_MUX_CONFIG, {SENSOR_REF, 1'b0, SENSOR_SELECT});
        chk("sensor_ref", 10'(reference_select), 10'(SENSOR_REF));
        chk("sensor_sel", 10'(input_select_field), 10'(SENSOR_SELECT));
        last_e = fmt(SENSOR_SELECT, 1'b0, 12'sh144);
        @(posedge clk);
        sample <= '{valid: 1'b1, value: 12'sh144};
        @(posedge clk);
        sample.valid <= 1'b0;
        bus_rd(ADDR_RESULT_LOW, rd_val);
        chk("sensor_low", 10'(rd_val), 10'(last_e[7:0]));
        bus_rd(ADDR_RESULT_HIGH, rd_val);
        chk("sensor_high", 10'(rd_val), 10'(last_e[9:8]));
        bus_wr(ADDR_STATUS, 8'h10);
        $display("test sensor done");
        repeat (200) begin
            convert(5'($urandom), 1'($urandom), 12'($urandom), 1'b1);
        end
        $display("test random done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
